// >>> rtl/phy_nextpage_mmd_energy_regs.sv
// Next-page capture, indirect MMD window and sleep link-pulse control
`timescale 1ns/1ps
// Overview of operation
// (R1) Bit 15 of received next page shows partner next-page ability, reset 0.
// (R2) Bit 14 becomes 1 once a link code word arrives, 0 before.
// (R3) Bit 13 message/unformatted flag; bits 10:0 received code, reset 0.
// (R4) Bit 12 shows partner second acknowledge flag.
// (R5) Bit 11 shows received toggle flag.
// (R6) Control bits 15:14 select function: 00 address, 01 data, others reserved.
// (R7) Control bits 4:0 select target device: 3 PCS, 7 auto-negotiation.
// (R8) In address mode a write to address/data sets the MMD address.
// (R9) Otherwise address/data reads and writes move data at stored address.
// (R10) Data accesses never change the stored MMD address.
// (R11) Bit 15 enables periodic link pulses while asleep at chosen interval.
// (R12) Pulses only with power-down enabled and PHY actually asleep.
// (R13) Software sets independent mode whenever it sets pulse enable.
// (R14) Bits 14:13 pick pulse interval: 1 s, 768, 512, 256 ms.
// (R15) Bit 12 set: one received link pulse wakes the PHY.
// (R16) Bit 12 clear: two pulses within the maximum spacing wake it.
// (R17) Bits 11:10 pick maximum spacing: 64, 256, 512 ms, 1 s.
// (R18) Bit 3 set: each port decides pulses from its own sleep state.
// (R19) Bit 3 clear: pulses only while both ports are asleep.
// (R20) Software should prefer single-pulse wake toward energy-saving gear.
// (R21) Sleep mode is entered only with power-down enable set.
// (R22) Soft-reset-cleared fields return to defaults on PHY soft reset.
// (R23) Reserved bits read zero and ignore writes.
module phy_nextpage_mmd_energy_regs
  import phy_regs_pkg::*;
#(
  // One clock rate sets every interval, so a faster test needs one knob
  parameter int CYC_PER_MS = int'(phy_regs_pkg::CLK_KHZ),
  parameter int TX_CYC_0   = int'(phy_regs_pkg::TX_INT0_MS * CYC_PER_MS),
  parameter int TX_CYC_1   = int'(phy_regs_pkg::TX_INT1_MS * CYC_PER_MS),
  parameter int TX_CYC_2   = int'(phy_regs_pkg::TX_INT2_MS * CYC_PER_MS),
  parameter int TX_CYC_3   = int'(phy_regs_pkg::TX_INT3_MS * CYC_PER_MS),
  parameter int RX_CYC_0   = int'(phy_regs_pkg::RX_INT0_MS * CYC_PER_MS),
  parameter int RX_CYC_1   = int'(phy_regs_pkg::RX_INT1_MS * CYC_PER_MS),
  parameter int RX_CYC_2   = int'(phy_regs_pkg::RX_INT2_MS * CYC_PER_MS),
  parameter int RX_CYC_3   = int'(phy_regs_pkg::RX_INT3_MS * CYC_PER_MS)
) (
  // Clock and resets
  input  wire logic        mclk_i,
  input  wire logic        reset_i,
  input  wire logic        soft_reset_cleared_i,
  // Management register access
  input  wire logic [4:0]  reg_index_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [15:0] reg_wdata_i,
  output logic [15:0]      reg_rdata_o,
  output logic             reg_rvalid_o,
  // Received next page from auto-negotiation
  input  wire logic        np_rx_valid_i,
  input  wire logic [15:0] np_rx_word_i,
  // Indirect MMD space
  output logic [4:0]       mmd_target_select_o,
  output logic [15:0]      mmd_addr_o,
  output logic             mmd_wr_o,
  output logic             mmd_rd_o,
  output logic [15:0]      mmd_wdata_o,
  input  wire logic [15:0] mmd_rdata_i,
  // Energy-detect power-down
  input  wire logic        energy_powerdown_enable_i,
  input  wire logic        energy_detect_sleep_i,
  input  wire logic        other_port_sleep_i,
  input  wire logic        nlp_rx_i,
  output logic             nlp_tx_o,
  output logic             wake_o
);

  localparam int TW = phy_regs_pkg::CNT_W;

  // Storage
  logic [15:0] np_rx;
  logic [15:0] mmd_ctrl;
  logic [15:0] mmd_addr;
  logic [15:0] energy_cfg;
  logic [15:0] next_rdata;

  // Address decode
  wire hit_np     = (reg_index_i == IDX_PARTNER_NP_RX);
  wire hit_ctrl   = (reg_index_i == IDX_MMD_CONTROL);
  wire hit_adat   = (reg_index_i == IDX_MMD_ADDR_DATA);
  wire hit_energy = (reg_index_i == IDX_ENERGY_CONFIG);

  // Indirect window decode
  wire [1:0] mmd_func  = mmd_ctrl[MMD_FUNC_LSB +: 2]; // R6
  wire       addr_mode = (mmd_func == MMD_FUNC_ADDRESS);
  wire       adat_wr   = reg_wr_i && hit_adat;
  wire       adat_rd   = reg_rd_i && hit_adat;
  wire       addr_load = adat_wr && addr_mode; // R8
  wire       data_wr   = adat_wr && !addr_mode; // R9
  wire       data_rd   = adat_rd && !addr_mode; // R9

  // Energy field decode
  wire       tx_en     = energy_cfg[EC_TX_EN_BIT];
  wire [1:0] tx_sel    = energy_cfg[EC_TX_INT_LSB +: 2];
  wire       single    = energy_cfg[EC_SINGLE_BIT];
  wire [1:0] rx_sel    = energy_cfg[EC_RX_INT_LSB +: 2];
  wire       indep     = energy_cfg[EC_INDEP_BIT];

  // Pick one of four interval counts
  function automatic logic [TW-1:0] pick(input logic [1:0] sel,
                                         input int c0, input int c1,
                                         input int c2, input int c3);
    case (sel)
      2'h0:    pick = TW'(c0);
      2'h1:    pick = TW'(c1);
      2'h2:    pick = TW'(c2);
      default: pick = TW'(c3);
    endcase
  endfunction

  wire [TW-1:0] tx_period =
    pick(tx_sel, TX_CYC_0, TX_CYC_1, TX_CYC_2, TX_CYC_3); // R14
  wire [TW-1:0] rx_max_gap =
    pick(rx_sel, RX_CYC_0, RX_CYC_1, RX_CYC_2, RX_CYC_3); // R17

  // Sleep only counts when power-down is enabled
  wire asleep     = energy_powerdown_enable_i && energy_detect_sleep_i; // R21
  // Without independent mode both ports must be asleep
  wire ports_ok   = indep || other_port_sleep_i; // R18 R19
  wire tx_run     = tx_en && asleep && ports_ok; // R11 R12

  // Read data selection; reserved bits come back as zero
  wire [15:0] adat_view = addr_mode ? mmd_addr : mmd_rdata_i;
  always_comb begin
    next_rdata = 16'h0000;
    if (hit_np) begin
      next_rdata = np_rx;
    end else if (hit_ctrl) begin
      next_rdata = mmd_ctrl & MASK_MMD_CTRL; // R23
    end else if (hit_adat) begin
      next_rdata = adat_view; // R9
    end else if (hit_energy) begin
      next_rdata = energy_cfg & MASK_ENERGY; // R23
    end
  end

  // Register read port: data one cycle after the read strobe
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      reg_rdata_o  <= 16'h0000;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        reg_rdata_o <= next_rdata;
      end
    end
  end

  // Captured next page; acknowledge is forced once a word arrived
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      np_rx <= RST_NP_RX;
    end else if (np_rx_valid_i) begin
      np_rx[NP_NEXT_BIT]       <= np_rx_word_i[NP_NEXT_BIT]; // R1
      np_rx[NP_ACK_BIT]        <= 1'b1; // R2
      np_rx[NP_MSG_BIT]        <= np_rx_word_i[NP_MSG_BIT]; // R3
      np_rx[NP_ACK2_BIT]       <= np_rx_word_i[NP_ACK2_BIT]; // R4
      np_rx[NP_TOGGLE_BIT]     <= np_rx_word_i[NP_TOGGLE_BIT]; // R5
      np_rx[NP_CODE_MSB:0]     <= np_rx_word_i[NP_CODE_MSB:0]; // R3
    end
  end

  // Indirect control: only function and target fields hold state
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      mmd_ctrl <= RST_MMD_CTRL;
    end else if (reg_wr_i && hit_ctrl) begin
      mmd_ctrl <= reg_wdata_i & MASK_MMD_CTRL; // R6 R7 R23
    end
  end

  // Stored MMD address changes only in address mode
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      mmd_addr <= RST_MMD_ADDR;
    end else if (addr_load) begin
      mmd_addr <= reg_wdata_i; // R8 R10
    end
  end

  // Energy configuration, also cleared by the PHY soft reset
  always_ff @(posedge mclk_i) begin
    if (reset_i || soft_reset_cleared_i) begin
      energy_cfg <= RST_ENERGY; // R22
    end else if (reg_wr_i && hit_energy) begin
      energy_cfg <= reg_wdata_i & MASK_ENERGY; // R23
    end
  end

  // MMD strobes registered so every output leaves a flip-flop; the
  // MMD side sees data accesses one cycle after the management strobe
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      mmd_target_select_o <= 5'h00;
      mmd_addr_o          <= 16'h0000;
      mmd_wr_o            <= 1'b0;
      mmd_rd_o            <= 1'b0;
      mmd_wdata_o         <= 16'h0000;
    end else begin
      mmd_target_select_o <= mmd_ctrl[MMD_DEV_MSB:0]; // R7
      mmd_addr_o          <= addr_load ? reg_wdata_i : mmd_addr;
      mmd_wr_o            <= data_wr; // R9
      mmd_rd_o            <= data_rd; // R9
      if (data_wr) begin
        mmd_wdata_o <= reg_wdata_i;
      end
    end
  end

  // Sleep link-pulse generator
  nlp_interval_timer #(
    .CNT_W (TW)
  ) u_tx_timer (
    .mclk_i   (mclk_i),
    .reset_i  (reset_i),
    .run_i    (tx_run),
    .period_i (tx_period),
    .tick_o   (nlp_tx_o)
  );

  // Wake detection while asleep
  nlp_wake_detect #(
    .CNT_W (TW)
  ) u_wake (
    .mclk_i    (mclk_i),
    .reset_i   (reset_i),
    .active_i  (asleep),
    .single_i  (single), // R15 R16
    .max_gap_i (rx_max_gap),
    .pulse_i   (nlp_rx_i),
    .wake_o    (wake_o)
  );

endmodule

// >>> rtl/phy_regs_pkg.sv
// Constants shared by the next-page, indirect MMD and energy config logic
package phy_regs_pkg;

  // Register indices on the management interface
  localparam logic [4:0] IDX_PARTNER_NP_RX   = 5'h08;
  localparam logic [4:0] IDX_MMD_CONTROL     = 5'h0d;
  localparam logic [4:0] IDX_MMD_ADDR_DATA   = 5'h0e;
  localparam logic [4:0] IDX_ENERGY_CONFIG   = 5'h10;

  // Received next-page field positions
  localparam int NP_NEXT_BIT   = 15;
  localparam int NP_ACK_BIT    = 14;
  localparam int NP_MSG_BIT    = 13;
  localparam int NP_ACK2_BIT   = 12;
  localparam int NP_TOGGLE_BIT = 11;
  localparam int NP_CODE_MSB   = 10;

  // Indirect control field positions and codes
  localparam int MMD_FUNC_LSB = 14;
  localparam int MMD_DEV_MSB  = 4;
  localparam logic [1:0] MMD_FUNC_ADDRESS = 2'h0;
  localparam logic [1:0] MMD_FUNC_DATA    = 2'h1;
  localparam logic [4:0] MMD_DEV_PCS      = 5'h03;
  localparam logic [4:0] MMD_DEV_AUTONEG  = 5'h07;

  // Energy configuration field positions
  localparam int EC_TX_EN_BIT   = 15;
  localparam int EC_TX_INT_LSB  = 13;
  localparam int EC_SINGLE_BIT  = 12;
  localparam int EC_RX_INT_LSB  = 10;
  localparam int EC_INDEP_BIT   = 3;

  // Reset values and writable-bit masks
  localparam logic [15:0] RST_NP_RX     = 16'h0000;
  localparam logic [15:0] RST_MMD_CTRL  = 16'h0000;
  localparam logic [15:0] RST_MMD_ADDR  = 16'h0000;
  localparam logic [15:0] RST_ENERGY    = 16'h0000;
  localparam logic [15:0] MASK_MMD_CTRL = 16'hc01f;
  localparam logic [15:0] MASK_ENERGY   = 16'hfc08;

  // Timing: clock rate and intervals in milliseconds
  localparam longint CLK_KHZ      = 20000;
  localparam longint TX_INT0_MS   = 1000;
  localparam longint TX_INT1_MS   = 768;
  localparam longint TX_INT2_MS   = 512;
  localparam longint TX_INT3_MS   = 256;
  localparam longint RX_INT0_MS   = 64;
  localparam longint RX_INT1_MS   = 256;
  localparam longint RX_INT2_MS   = 512;
  localparam longint RX_INT3_MS   = 1000;
  localparam int     CNT_W        = 25;
  localparam int TX_INT0_CYC = int'(TX_INT0_MS * CLK_KHZ);
  localparam int TX_INT1_CYC = int'(TX_INT1_MS * CLK_KHZ);
  localparam int TX_INT2_CYC = int'(TX_INT2_MS * CLK_KHZ);
  localparam int TX_INT3_CYC = int'(TX_INT3_MS * CLK_KHZ);
  localparam int RX_INT0_CYC = int'(RX_INT0_MS * CLK_KHZ);
  localparam int RX_INT1_CYC = int'(RX_INT1_MS * CLK_KHZ);
  localparam int RX_INT2_CYC = int'(RX_INT2_MS * CLK_KHZ);
  localparam int RX_INT3_CYC = int'(RX_INT3_MS * CLK_KHZ);

  typedef enum logic [1:0] {
    WAKE_IDLE,
    WAKE_ARMED
  } wake_state_t;

endpackage

// >>> rtl/nlp_interval_timer.sv
// Periodic pulse generator for link pulses sent while asleep
`timescale 1ns/1ps
module nlp_interval_timer #(
  parameter int CNT_W = 25
) (
  // Clock and reset
  input  wire logic             mclk_i,
  input  wire logic             reset_i,
  // Control
  input  wire logic             run_i,
  input  wire logic [CNT_W-1:0] period_i,
  // Output
  output logic                  tick_o
);

  logic [CNT_W-1:0] count;
  wire              at_end = (count >= period_i - CNT_W'(1));

  // Restarts from zero whenever it is stopped, so the first pulse
  // comes one full interval after entering sleep
  always_ff @(posedge mclk_i) begin
    if (reset_i || !run_i) begin
      count  <= '0;
      tick_o <= 1'b0;
    end else if (at_end) begin
      count  <= '0;
      tick_o <= 1'b1;
    end else begin
      count  <= count + CNT_W'(1);
      tick_o <= 1'b0;
    end
  end

endmodule

// >>> rtl/nlp_wake_detect.sv
// Wake detector: one pulse, or two pulses within a maximum spacing
`timescale 1ns/1ps
module nlp_wake_detect
  import phy_regs_pkg::*;
#(
  parameter int CNT_W = 25
) (
  // Clock and reset
  input  wire logic             mclk_i,
  input  wire logic             reset_i,
  // Control
  input  wire logic             active_i,
  input  wire logic             single_i,
  input  wire logic [CNT_W-1:0] max_gap_i,
  input  wire logic             pulse_i,
  // Output
  output logic                  wake_o
);

  wake_state_t      state;
  logic [CNT_W-1:0] gap;
  wire              gap_ok = (gap < max_gap_i);

  always_ff @(posedge mclk_i) begin
    if (reset_i || !active_i) begin
      state  <= WAKE_IDLE;
      gap    <= '0;
      wake_o <= 1'b0;
    end else begin
      wake_o <= 1'b0;
      case (state)
        WAKE_IDLE: begin
          gap <= '0;
          if (pulse_i && single_i) begin
            wake_o <= 1'b1; // R15
          end else if (pulse_i) begin
            state <= WAKE_ARMED;
          end
        end
        WAKE_ARMED: begin
          if (pulse_i && gap_ok) begin
            wake_o <= 1'b1; // R16
            state  <= WAKE_IDLE;
          end else if (pulse_i) begin
            gap <= '0; // Late pulse becomes the new first pulse
          end else if (!gap_ok) begin
            state <= WAKE_IDLE;
          end else begin
            gap <= gap + CNT_W'(1);
          end
        end
        default: state <= WAKE_IDLE;
      endcase
    end
  end

endmodule

// >>> verification/mmd_space_model.sv
// Behavioural MMD register space behind the indirect window
`timescale 1ns/1ps
module mmd_space_model (
  // Clock
  input  wire logic        mclk_i,
  // Window side
  input  wire logic [4:0]  target_i,
  input  wire logic [15:0] addr_i,
  input  wire logic        wr_i,
  input  wire logic [15:0] wdata_i,
  output logic [15:0]      rdata_o
);
  logic [15:0] mem [32][16];
  initial begin
    for (int t = 0; t < 32; t++) begin
      for (int a = 0; a < 16; a++) begin
        mem[t][a] = 16'(t * 16 + a) ^ 16'ha5a5;
      end
    end
  end
  // Only low address bits are kept; enough to tell locations apart
  assign rdata_o = mem[target_i][addr_i[3:0]];
  always @(posedge mclk_i) begin
    if (wr_i) begin
      mem[target_i][addr_i[3:0]] <= wdata_i;
    end
  end
endmodule

// >>> verification/phy_regs_monitor.sv
// Port checker for the next-page, MMD window and sleep pulse block
`timescale 1ns/1ps
module phy_regs_monitor
  import phy_regs_pkg::*;
(
  // Clock and reset
  input wire logic        mclk_i,
  input wire logic        reset_i,
  // Register access
  input wire logic [4:0]  reg_index_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic        reg_rvalid_o,
  // MMD side
  input wire logic [15:0] mmd_addr_o,
  input wire logic        mmd_wr_o,
  input wire logic        mmd_rd_o,
  input wire logic [15:0] mmd_wdata_o,
  // Sleep control
  input wire logic        energy_powerdown_enable_i,
  input wire logic        energy_detect_sleep_i,
  input wire logic        nlp_rx_i,
  input wire logic        nlp_tx_o,
  input wire logic        wake_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  property p_rd_ans; reg_rd_i |=> reg_rvalid_o; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("no rvalid");
  property p_rd_quiet; !reg_rd_i |=> !reg_rvalid_o; endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("stray rvalid");
  property p_ctl_rsv;
    reg_rvalid_o && $past(reg_index_i) == IDX_MMD_CONTROL
      |-> (reg_rdata_o & ~MASK_MMD_CTRL) == 16'h0000;
  endproperty
  a_ctl_rsv: assert property (p_ctl_rsv) else $error("ctl rsvd set");
  property p_en_rsv;
    reg_rvalid_o && $past(reg_index_i) == IDX_ENERGY_CONFIG
      |-> (reg_rdata_o & ~MASK_ENERGY) == 16'h0000;
  endproperty
  a_en_rsv: assert property (p_en_rsv) else $error("cfg rsvd set");
  property p_np_ack;
    reg_rvalid_o && $past(reg_index_i) == IDX_PARTNER_NP_RX
      && reg_rdata_o != 16'h0000 |-> reg_rdata_o[NP_ACK_BIT];
  endproperty
  a_np_ack: assert property (p_np_ack) else $error("ack clear");
  property p_wdata;
    mmd_wr_o |-> $past(reg_wr_i) && $past(reg_index_i) == IDX_MMD_ADDR_DATA
      && mmd_wdata_o == $past(reg_wdata_i);
  endproperty
  a_wdata: assert property (p_wdata) else $error("bad mmd write");
  property p_addr_hold;
    mmd_wr_o || mmd_rd_o |-> $stable(mmd_addr_o);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("addr moved");
  property p_tx_gate;
    nlp_tx_o |-> $past(energy_powerdown_enable_i)
      && $past(energy_detect_sleep_i);
  endproperty
  a_tx_gate: assert property (p_tx_gate) else $error("tx awake");
  property p_wake;
    wake_o |-> $past(nlp_rx_i) && $past(energy_powerdown_enable_i);
  endproperty
  a_wake: assert property (p_wake) else $error("wake no pulse");
  property p_mmd_rd;
    mmd_rd_o |-> $past(reg_rd_i) && $past(reg_index_i) == IDX_MMD_ADDR_DATA;
  endproperty
  a_mmd_rd: assert property (p_mmd_rd) else $error("stray mmd read");
endmodule
bind phy_nextpage_mmd_energy_regs phy_regs_monitor u_mon (
  .mclk_i(mclk_i), .reset_i(reset_i), .reg_index_i(reg_index_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
  .mmd_addr_o(mmd_addr_o), .mmd_wr_o(mmd_wr_o), .mmd_rd_o(mmd_rd_o),
  .mmd_wdata_o(mmd_wdata_o), .nlp_rx_i(nlp_rx_i), .nlp_tx_o(nlp_tx_o),
  .energy_powerdown_enable_i(energy_powerdown_enable_i),
  .energy_detect_sleep_i(energy_detect_sleep_i), .wake_o(wake_o)
);

// >>> verification/testbench.sv
// Self-checking bench for the next-page, MMD window and sleep pulse block
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_count++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module testbench;
  import phy_regs_pkg::*;
  // One cycle per millisecond keeps the longest interval near 1000 cycles
  localparam int MS = 1;
  localparam int TXC [4] = '{int'(TX_INT0_MS) * MS, int'(TX_INT1_MS) * MS,
                             int'(TX_INT2_MS) * MS, int'(TX_INT3_MS) * MS};
  localparam int RXC [4] = '{int'(RX_INT0_MS) * MS, int'(RX_INT1_MS) * MS,
                             int'(RX_INT2_MS) * MS, int'(RX_INT3_MS) * MS};
  logic        mclk_i = 1'b0, reset_i = 1'b1, soft_reset_cleared_i = 1'b0;
  logic [4:0]  reg_index_i = 5'h00, mmd_target_select_o;
  logic        reg_wr_i = 1'b0, reg_rd_i = 1'b0, np_rx_valid_i = 1'b0;
  logic [15:0] reg_wdata_i = 16'h0000, np_rx_word_i = 16'h0000;
  logic        energy_powerdown_enable_i = 1'b0, nlp_rx_i = 1'b0;
  logic        energy_detect_sleep_i = 1'b0, other_port_sleep_i = 1'b0;
  logic [15:0] reg_rdata_o, mmd_addr_o, mmd_wdata_o, mmd_rdata_i, rd_val;
  logic        reg_rvalid_o, mmd_wr_o, mmd_rd_o, nlp_tx_o, wake_o;
  int          err_count = 0, checked = 0;
  always #25 mclk_i = ~mclk_i;
  phy_nextpage_mmd_energy_regs #(.CYC_PER_MS(MS)) dut (
    .mclk_i(mclk_i), .reset_i(reset_i), .reg_index_i(reg_index_i),
    .soft_reset_cleared_i(soft_reset_cleared_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .wake_o(wake_o),
    .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
    .np_rx_valid_i(np_rx_valid_i), .np_rx_word_i(np_rx_word_i),
    .mmd_target_select_o(mmd_target_select_o), .mmd_addr_o(mmd_addr_o),
    .mmd_wr_o(mmd_wr_o), .mmd_rd_o(mmd_rd_o), .mmd_wdata_o(mmd_wdata_o),
    .mmd_rdata_i(mmd_rdata_i), .nlp_rx_i(nlp_rx_i), .nlp_tx_o(nlp_tx_o),
    .energy_powerdown_enable_i(energy_powerdown_enable_i),
    .energy_detect_sleep_i(energy_detect_sleep_i),
    .other_port_sleep_i(other_port_sleep_i));
  mmd_space_model mmd (.mclk_i(mclk_i), .target_i(mmd_target_select_o),
    .addr_i(mmd_addr_o), .wr_i(mmd_wr_o), .wdata_i(mmd_wdata_o),
    .rdata_o(mmd_rdata_i));
  task automatic complete_run();
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic step(int n = 1);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  // Trailing idle cycle keeps a strobe from being rewritten in one step
  task automatic wr(logic [4:0] idx, logic [15:0] d);
    reg_index_i = idx;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    step();
    reg_wr_i = 1'b0;
    step();
  endtask
  task automatic chk_rd(logic [4:0] idx, logic [15:0] e, string n);
    int k = 0;
    reg_index_i = idx;
    reg_rd_i = 1'b1;
    step();
    reg_rd_i = 1'b0;
    while (reg_rvalid_o !== 1'b1 && k < 4) begin
      step();
      k++;
    end
    if (k == 4) begin
      err_count++;
      complete_run();
    end
    `CHK(n, e, reg_rdata_o)
    step();
  endtask
  task automatic np_send(logic [15:0] w);
    np_rx_word_i = w;
    np_rx_valid_i = 1'b1;
    step();
    np_rx_valid_i = 1'b0;
    step();
  endtask
  task automatic gap(output int n);
    n = 0;
    do begin
      step();
      n++;
    end while (nlp_tx_o !== 1'b1 && n < 1200);
    if (n >= 1200) begin
      err_count++;
      complete_run();
    end
  endtask
  task automatic tx_count(int len, output int c);
    c = 0;
    repeat (len) begin
      step();
      c += int'(nlp_tx_o === 1'b1);
    end
  endtask
  task automatic rx_pulse(output logic w);
    nlp_rx_i = 1'b1;
    step();
    nlp_rx_i = 1'b0;
    w = wake_o;
    step();
  endtask
  task automatic t_reset_vals();
    chk_rd(IDX_PARTNER_NP_RX, 16'h0000, "np");
    chk_rd(IDX_MMD_CONTROL, 16'h0000, "ctl");
    chk_rd(IDX_MMD_ADDR_DATA, 16'h0000, "ad");
    chk_rd(IDX_ENERGY_CONFIG, 16'h0000, "cfg");
    wr(5'h05, 16'hffff);
    chk_rd(5'h05, 16'h0000, "unmapped");
  endtask
  task automatic t_next_page();
    np_send(16'hb805);
    chk_rd(IDX_PARTNER_NP_RX, 16'hf805, "np1");
    wr(IDX_PARTNER_NP_RX, 16'h0000);
    chk_rd(IDX_PARTNER_NP_RX, 16'hf805, "np ro");
    np_send(16'h0002);
    chk_rd(IDX_PARTNER_NP_RX, 16'h4002, "np2");
  endtask
  task automatic t_mmd();
    logic [4:0] tg [2] = '{MMD_DEV_PCS, MMD_DEV_AUTONEG};
    foreach (tg[i]) begin
      wr(IDX_MMD_CONTROL, {MMD_FUNC_ADDRESS, 9'h000, tg[i]});
      wr(IDX_MMD_ADDR_DATA, 16'h0005 + tg[i]);
      `CHK("target", tg[i], mmd_target_select_o)
      `CHK("addr", 16'h0005 + tg[i], mmd_addr_o)
      wr(IDX_MMD_CONTROL, {MMD_FUNC_DATA, 9'h000, tg[i]});
      wr(IDX_MMD_ADDR_DATA, 16'hbe00 + tg[i]);
      `CHK("wdata", 16'hbe00 + tg[i], mmd_wdata_o)
      chk_rd(IDX_MMD_ADDR_DATA, 16'hbe00 + tg[i], "rdata");
      `CHK("addr kept", 16'h0005 + tg[i], mmd_addr_o)
    end
    wr(IDX_MMD_CONTROL, 16'hffff);
    chk_rd(IDX_MMD_CONTROL, 16'hc01f, "ctl mask");
    wr(IDX_MMD_ADDR_DATA, 16'h1111);
    `CHK("rsvd func", 16'h000c, mmd_addr_o)
  endtask
  task automatic t_energy();
    wr(IDX_ENERGY_CONFIG, 16'hffff);
    chk_rd(IDX_ENERGY_CONFIG, 16'hfc08, "cfg mask");
    soft_reset_cleared_i = 1'b1;
    step();
    soft_reset_cleared_i = 1'b0;
    chk_rd(IDX_ENERGY_CONFIG, 16'h0000, "cfg soft");
    chk_rd(IDX_MMD_CONTROL, 16'hc01f, "ctl soft");
  endtask
  task automatic t_tx();
    int g;
    energy_powerdown_enable_i = 1'b1;
    energy_detect_sleep_i = 1'b1;
    for (int c = 0; c < 4; c++) begin
      wr(IDX_ENERGY_CONFIG, 16'h8008 | (16'(c) << 13));
      gap(g);
      gap(g);
      `CHK("tx gap", TXC[c], g)
    end
    wr(IDX_ENERGY_CONFIG, 16'h8000);
    tx_count(1100, g);
    `CHK("both asleep", 0, g)
    other_port_sleep_i = 1'b1;
    gap(g);
    gap(g);
    `CHK("tx pair", TXC[0], g)
    energy_powerdown_enable_i = 1'b0;
    tx_count(1100, g);
    `CHK("tx no pden", 0, g)
    energy_powerdown_enable_i = 1'b1;
    wr(IDX_ENERGY_CONFIG, 16'h0008);
    tx_count(1100, g);
    `CHK("tx off", 0, g)
  endtask
  task automatic t_wake();
    logic w;
    wr(IDX_ENERGY_CONFIG, 16'h1000);
    rx_pulse(w);
    `CHK("wake single", 1'b1, w)
    energy_powerdown_enable_i = 1'b0;
    rx_pulse(w);
    `CHK("wake no pden", 1'b0, w)
    energy_powerdown_enable_i = 1'b1;
    for (int c = 0; c < 4; c++) begin
      wr(IDX_ENERGY_CONFIG, 16'(c) << 10);
      rx_pulse(w);
      `CHK("wake first", 1'b0, w)
      step(RXC[c] / 2);
      rx_pulse(w);
      `CHK("wake pair", 1'b1, w)
      rx_pulse(w);
      step(RXC[c] + 3);
      rx_pulse(w);
      `CHK("wake late", 1'b0, w)
      step(RXC[c] + 3);
    end
  endtask
  initial begin
    step(16);
    reset_i = 1'b0;
    step();
    t_reset_vals();
    t_next_page();
    t_mmd();
    t_energy();
    t_tx();
    t_wake();
    complete_run();
  end
endmodule
